/* fault_event_manager.sv */
// fault event manager: watches supply, temperature, current, dc and
// sync clock detectors, reports channel states, live status and
// clear-on-read memory latches over a simple register port.
// assumes the power-on reset drives rst_n_i and the host polls.
`timescale 1ns/10ps
`include "fault_event_manager_defs.svh"

module fault_event_manager (
    // clock, reset, enable
    input  wire logic                          clk_sys_i,
    input  wire logic                          rst_n_i,
    input  wire logic                          ce_i,
    // detector pins
    input  wire fault_event_manager_pkg::det_t det_i,
    // register port
    input  wire fault_event_manager_pkg::reg_req_t req_i,
    output logic [7:0]                         rdata_o,
    // channel state report
    output fault_event_manager_pkg::chan_vec_t chan_state_o
);
    import fault_event_manager_pkg::*;

    // ==========================================================
    // reset release
    logic [1:0] rst_pipe_q;  // release pipe, assert is immediate
    logic       rst_n_q;     // synchronised reset for the block

    // not frozen by ce_i so a stopped clock enable cannot hold
    // the block in reset forever
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_pipe_q <= 2'b00;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end
    assign rst_n_q = rst_pipe_q[1];

    // ==========================================================
    // detector synchronisers
    det_t det_m_q;  // first stage, read only by second stage
    det_t det_s_q;  // usable copy

    always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            det_m_q <= '0;
            det_s_q <= '0;
        end else if (ce_i) begin
            det_m_q <= det_i;
            det_s_q <= det_m_q;
        end
    end

    // ==========================================================
    // helpers
    // memory latch: read clears, a new event in the same cycle
    // wins over the clear
    function automatic logic [7:0] latch_next(
        input logic [7:0] q,
        input logic [7:0] ev,
        input logic       clr
    );
        latch_next = (clr ? `FEM_ZERO : q) | ev;
    endfunction

    // next reported state of one channel
    function automatic chan_state_t chan_next(
        input chan_state_t cur,
        input logic        lat,
        input logic        ar,
        input logic        play
    );
        if (lat) begin
            chan_next = CH_PSD;
        end else if (ar) begin
            chan_next = CH_PSD_AR;
        end else if (cur == CH_PSD) begin
            // cleared latch with no auto-recovering cause passes through Hi-Z first
            chan_next = CH_HIZ;
        end else begin
            chan_next = play ? CH_PLAY : CH_HIZ;
        end
    endfunction

    // ==========================================================
    // control register
    logic [7:0] ctrl_q;    // auto-recovery, follower, play enables
    logic       clr_q;     // one-cycle clear-fault pulse
    logic       wr_ctrl;   // write to control this cycle
    logic       ot_auto;   // over-temp auto recovery selected
    logic       follow;    // clock follower mode

    assign wr_ctrl = req_i.wr && (req_i.addr == `FEM_A_CTRL);
    assign ot_auto = ctrl_q[`FEM_CTL_OTAR];
    assign follow  = ctrl_q[`FEM_CTL_FOLLOW];

    // clear bit is never stored, it acts once and reads back 0
    always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_q <= `FEM_CTRL_RST;
        end else if (ce_i && wr_ctrl) begin
            ctrl_q <= req_i.wdata & ~(8'h01 << `FEM_CTL_CLR_BIT);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            clr_q <= 1'b0;
        end else if (ce_i) begin
            clr_q <= wr_ctrl && req_i.wdata[`FEM_CTL_CLR_BIT];
        end
    end

    // ==========================================================
    // event vectors
    logic [4:0] pwr_vec;  // live supply faults
    logic [5:0] ot_vec;   // live over-temp and clock faults
    logic       clk_bad;  // clock loss counts only as follower
    logic       pwr_any;  // any supply fault present
    logic [3:0] lat_ev;   // latching events per channel
    logic [3:0] ar_ev;    // auto-recovering causes per channel
    logic [3:0] ot_any;   // channel or global over-temp

    assign clk_bad = det_s_q.clk_invalid && follow;
    assign pwr_vec = {det_s_q.gate_drive_supply_fault,
                      det_s_q.power_stage_supply_uv,
                      det_s_q.power_stage_supply_ov,
                      det_s_q.vbat_uv,
                      det_s_q.vbat_ov};
    assign ot_vec  = {clk_bad, det_s_q.ot_global, det_s_q.ot_ch};
    assign pwr_any = |pwr_vec;
    assign ot_any  = det_s_q.ot_ch | {4{det_s_q.ot_global}};

    // over-temp latches by default, recovers when selected
    assign lat_ev = det_s_q.over_current_shutdown_ch
                  | det_s_q.load_ch
                  | det_s_q.dc_ch
                  | (ot_auto ? 4'h0 : ot_any);
    assign ar_ev  = {4{pwr_any | clk_bad}}
                  | (ot_auto ? ot_any : 4'h0);

    // ==========================================================
    // channel fault latches and states
    logic [3:0] latched_q;  // latched shutdown per channel
    chan_vec_t  state_q;    // reported state per channel

    // new event beats a simultaneous clear
    always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            latched_q <= 4'h0;
        end else if (ce_i) begin
            latched_q <= (clr_q ? 4'h0 : latched_q) | lat_ev;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= '{default: CH_HIZ};
        end else if (ce_i) begin
            for (int i = 0; i < 4; i++) begin
                state_q[i] <= chan_next(state_q[i],
                    lat_ev[i] | (latched_q[i] & ~clr_q),
                    ar_ev[i],
                    ctrl_q[`FEM_CTL_PLAY + i]);
            end
        end
    end
    assign chan_state_o = state_q;

    // ==========================================================
    // status and memory registers
    logic [7:0] pwr_sta_q;   // live supply faults, no reset event
    logic [7:0] pwr_mem_q;   // latched supply faults, reset flag
    logic [7:0] ot_sta_q;    // live over-temp and clock
    logic [7:0] ot_mem_q;    // latched over-temp and clock
    logic [7:0] ocdc_mem_q;  // latched over-current and dc
    logic [7:0] load_mem_q;  // latched load current fault

    // read strobe that clears a given memory register
    function automatic logic rd_clr(input logic [3:0] a);
        rd_clr = req_i.rd && (req_i.addr == a);
    endfunction

    // status is a plain mirror, bit 5 of the supply status stays zero
    always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pwr_sta_q <= `FEM_ZERO;
            ot_sta_q  <= `FEM_ZERO;
        end else if (ce_i) begin
            pwr_sta_q <= {3'h0, pwr_vec};
            ot_sta_q  <= {2'h0, ot_vec};
        end
    end

    // reset value carries the stored power-on flag
    always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pwr_mem_q <= `FEM_PWR_MEM_RST;
        end else if (ce_i) begin
            pwr_mem_q <= latch_next(pwr_mem_q, {3'h0, pwr_vec},
                                    rd_clr(`FEM_A_PWR_MEM));
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ot_mem_q <= `FEM_ZERO;
        end else if (ce_i) begin
            ot_mem_q <= latch_next(ot_mem_q, {2'h0, ot_vec},
                                   rd_clr(`FEM_A_OT_MEM));
        end
    end

    // load fault also raises the over-current latch
    always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ocdc_mem_q <= `FEM_ZERO;
        end else if (ce_i) begin
            ocdc_mem_q <= latch_next(ocdc_mem_q,
                {det_s_q.dc_ch,
                 det_s_q.over_current_shutdown_ch | det_s_q.load_ch},
                rd_clr(`FEM_A_OCDC_MEM));
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            load_mem_q <= `FEM_ZERO;
        end else if (ce_i) begin
            load_mem_q <= latch_next(load_mem_q,
                {4'h0, det_s_q.load_ch},
                rd_clr(`FEM_A_LOAD_MEM));
        end
    end

    // ==========================================================
    // read data, valid the cycle after the strobe
    logic [7:0] rd_mux;  // selected register
    logic [7:0] rdata_q; // read data flop

    always_comb begin
        unique case (req_i.addr)
            `FEM_A_STATE12:  rd_mux = {1'b0, state_q[1],
                                       1'b0, state_q[0]};
            `FEM_A_STATE34:  rd_mux = {1'b0, state_q[3],
                                       1'b0, state_q[2]};
            `FEM_A_PWR_STA:  rd_mux = pwr_sta_q;
            `FEM_A_PWR_MEM:  rd_mux = pwr_mem_q;
            `FEM_A_OT_STA:   rd_mux = ot_sta_q;
            `FEM_A_OT_MEM:   rd_mux = ot_mem_q;
            `FEM_A_OCDC_MEM: rd_mux = ocdc_mem_q;
            `FEM_A_LOAD_MEM: rd_mux = load_mem_q;
            `FEM_A_CTRL:     rd_mux = ctrl_q;
            default:         rd_mux = `FEM_ZERO; // unmapped reads 0
        endcase
    end

    // old content is returned while the latch clears on this edge;
    // a reset drops any access under way
    always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= `FEM_ZERO;
        end else if (ce_i) begin
            rdata_q <= req_i.rd ? rd_mux : `FEM_ZERO;
        end
    end
    assign rdata_o = rdata_q;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_q);

    property p_pwr_latch;
        ce_i && det_s_q.vbat_ov |=> pwr_mem_q[0] && pwr_sta_q[0];
    endproperty
    a_pwr_latch: assert property (p_pwr_latch)
        else $error("supply fault not shown live and latched");

    property p_mem_rd_clear;
        ce_i && rd_clr(`FEM_A_OCDC_MEM) && !(|det_s_q.dc_ch)
            && !(|(det_s_q.over_current_shutdown_ch | det_s_q.load_ch))
            |=> ocdc_mem_q == `FEM_ZERO && rdata_q == $past(ocdc_mem_q);
    endproperty
    a_mem_rd_clear: assert property (p_mem_rd_clear)
        else $error("memory read did not return and clear");

    property p_por_defaults;
        $rose(rst_n_q) |-> state_q == {4{CH_HIZ}}
            && pwr_mem_q[`FEM_PWR_POR_BIT] && rdata_q == `FEM_ZERO;
    endproperty
    a_por_defaults: assert property (p_por_defaults)
        else $error("state after power-on reset is wrong");

    property p_no_por_live;
        pwr_sta_q[`FEM_PWR_POR_BIT] == 1'b0;
    endproperty
    a_no_por_live: assert property (p_no_por_live)
        else $error("reset event shown in live status");

    property p_supply_ar;
        ce_i && det_s_q.power_stage_supply_uv && !lat_ev[0]
            && !latched_q[0]
            |=> state_q[0] == CH_PSD_AR;
    endproperty
    a_supply_ar: assert property (p_supply_ar)
        else $error("supply fault did not give code 100");

    // the shutdown must outlive the event until a clear is applied
    property p_oc_latch;
        ce_i && det_s_q.over_current_shutdown_ch[2] |=> state_q[2] == CH_PSD
            && ocdc_mem_q[2] ##1 (!$past(ce_i) || $past(clr_q)
            || state_q[2] == CH_PSD);
    endproperty
    a_oc_latch: assert property (p_oc_latch)
        else $error("over-current did not latch shutdown");

    property p_dc_latch;
        ce_i && det_s_q.dc_ch[3] |=> state_q[3] == CH_PSD
            && ocdc_mem_q[7];
    endproperty
    a_dc_latch: assert property (p_dc_latch)
        else $error("dc fault did not latch shutdown");

    property p_ot_auto;
        ce_i && ot_auto && det_s_q.ot_global && !latched_q[2]
            && !(det_s_q.over_current_shutdown_ch[2] | det_s_q.dc_ch[2]
                 | det_s_q.load_ch[2])
            |=> state_q[2] == CH_PSD_AR && !latched_q[2];
    endproperty
    a_ot_auto: assert property (p_ot_auto)
        else $error("over-temp auto recovery not honoured");

    property p_clear_fault;
        ce_i && clr_q && state_q[3] == CH_PSD && !lat_ev[3]
            && !ar_ev[3] |=> state_q[3] == CH_HIZ && !latched_q[3];
    endproperty
    a_clear_fault: assert property (p_clear_fault)
        else $error("clear fault did not move channel to Hi-Z");

    c_ar_recover: cover property (state_q[0] == CH_PSD_AR
        ##[1:20] state_q[0] == CH_PLAY);
    c_latch_clear: cover property (state_q[1] == CH_PSD
        ##[1:20] state_q[1] == CH_HIZ);
    c_mem_read: cover property (req_i.rd
        && req_i.addr == `FEM_A_PWR_MEM && pwr_mem_q != `FEM_ZERO);
    c_clock_loss: cover property (follow && ot_sta_q[5]);

endmodule

/* fault_event_manager_defs.svh */
// constants for the fault event manager: register offsets, field
// positions and reset values; included by the design and the bench.
// assumes an 8-bit register port with a 4-bit word address.
//
// Functional notes
// - live supply faults in status, also latched
// - reading memory clears it, not the fault
// - core supply drop: shutdown, Hi-Z, abort access
// - core supply rise: all state back to default
// - reset-stored flag set after every power-on
// - reset event only in memory, never status
// - battery over-voltage: auto-recovering shutdown
// - battery under-voltage: auto-recovering shutdown
// - power stage over-voltage: auto-recovering shutdown
// - power stage under-voltage: auto-recovering shutdown
// - supply and gate-drive faults report code 100
// - after reset channels read 001 Hi-Z
// - over-current or load fault: latched, memory only
// - dc fault: latched 101, memory only
// - follower clock loss: 100, live and latched
// - gate-drive fault is auto-recovering power fault
// - over-temp auto-recovery bit selects code 100
// - clear-fault bit: latched channels go Hi-Z
`ifndef FAULT_EVENT_MANAGER_DEFS_SVH
`define FAULT_EVENT_MANAGER_DEFS_SVH

// ==========================================================
// register offsets (word addresses)
`define FEM_A_STATE12   4'h0
`define FEM_A_STATE34   4'h1
`define FEM_A_PWR_STA   4'h2
`define FEM_A_PWR_MEM   4'h3
`define FEM_A_OT_STA    4'h4
`define FEM_A_OT_MEM    4'h5
`define FEM_A_OCDC_MEM  4'h6
`define FEM_A_LOAD_MEM  4'h7
`define FEM_A_CTRL      4'h8

// ==========================================================
// field positions
`define FEM_PWR_POR_BIT 5
`define FEM_CTL_CLR_BIT 0
`define FEM_CTL_OTAR    1
`define FEM_CTL_FOLLOW  2
`define FEM_CTL_PLAY    4

// ==========================================================
// reset values
`define FEM_PWR_MEM_RST 8'h20
`define FEM_CTRL_RST    8'h00
`define FEM_ZERO        8'h00

`endif

/* fault_event_manager_pkg.sv */
// types shared by the fault event manager and its surroundings.
// assumes the constants header sits in the same folder.
package fault_event_manager_pkg;

    // ==========================================================
    // reported channel state codes
    typedef enum logic [2:0] {
        CH_HIZ    = 3'h1,  // outputs off, idle
        CH_PLAY   = 3'h3,  // switching with audio
        CH_PSD_AR = 3'h4,  // protective shutdown, auto recovery
        CH_PSD    = 3'h5   // protective shutdown, latched
    } chan_state_t;

    typedef chan_state_t [3:0] chan_vec_t;

    // ==========================================================
    // detector inputs, all asynchronous to the core clock
    typedef struct packed {
        logic       vbat_ov;      // battery over-voltage
        logic       vbat_uv;      // battery under-voltage
        logic       power_stage_supply_ov;    // power stage over-voltage
        logic       power_stage_supply_uv;    // power stage under-voltage
        logic       gate_drive_supply_fault;  // gate drive regulator fault
        logic       clk_invalid;  // sync clock out of range
        logic       ot_global;    // die over-temp shutdown
        logic [3:0] ot_ch;        // channel over-temp shutdown
        logic [3:0] over_current_shutdown_ch; // over-current shutdown
        logic [3:0] dc_ch;        // dc fault
        logic [3:0] load_ch;      // load current fault
    } det_t;

    // ==========================================================
    // register port request, same clock as the block
    typedef struct packed {
        logic       wr;     // write strobe
        logic       rd;     // read strobe
        logic [3:0] addr;   // word address
        logic [7:0] wdata;  // write data
    } reg_req_t;

endpackage

/* host_model.sv */
// host side of the register port: polls and configures the fault block.
// assumes the bench calls its tasks and shares the core clock with it.
`timescale 1ns/10ps

module host_model (
    // clock
    input  wire logic                             clk_sys_i,
    // register port
    input  wire logic [7:0]                       rdata_i,
    output fault_event_manager_pkg::reg_req_t     req_o
);
    import fault_event_manager_pkg::*;

    // ==========================================================
    // idle port at time zero
    initial begin
        req_o = '0;
    end

    // ==========================================================
    // one-cycle write strobe; config rewrite and clear-fault go here
    task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys_i);
        req_o <= '0;
    endtask

    // one-cycle read strobe; data only stand in the following cycle
    task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys_i);
        req_o <= '0;
        #1;
        d = rdata_i; // sampled once settled, before the next edge
    endtask
endmodule

/* tb_top.sv */
// self-checking bench for the fault event manager.
// assumes the host model drives the register port and the bench the pins.
`timescale 1ns/10ps
`include "fault_event_manager_defs.svh"

module tb_top;
    import fault_event_manager_pkg::*;

    // ==========================================================
    // signals
    logic        clk_sys_i = 1'b0; // core clock
    logic        rst_n_i   = 1'b1; // high, so the time 0 fall resets all
    logic        ce_i      = 1'b1; // clock enable
    det_t        det_i     = '0;   // detector levels
    reg_req_t    req_i;            // from the host model
    logic [7:0]  rdata_o;          // read data
    chan_vec_t   chan_state_o;     // channel reports
    int          n_errors     = 0; // mismatches
    int          total_checks = 0; // comparisons
    logic [11:0] ev;               // scratch expectation
    int          i;                // loop index

    // ==========================================================
    // 40 MHz clock
    always begin
        #12.5 clk_sys_i = ~clk_sys_i;
    end

    // ==========================================================
    // device and host
    fault_event_manager dut (
        .clk_sys_i    (clk_sys_i),
        .rst_n_i      (rst_n_i),
        .ce_i         (ce_i),
        .det_i        (det_i),
        .req_i        (req_i),
        .rdata_o      (rdata_o),
        .chan_state_o (chan_state_o)
    );

    host_model host (
        .clk_sys_i (clk_sys_i),
        .rdata_i   (rdata_o),
        .req_o     (req_i)
    );

    // ==========================================================
    // helpers
    task automatic check(input string w, input logic [11:0] seen,
                         input logic [11:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", w, exp, seen);
        end
    endtask

    // read one register and compare its byte
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.read_reg(a, d);
        check($sformatf("reg %h", a), {4'h0, d}, {4'h0, e});
    endtask

    // all four channels alike, channel k may differ
    function automatic logic [11:0] chv(chan_state_t b, int k,
                                        chan_state_t o);
        logic [11:0] r;
        r = {b, b, b, b};
        r[k*3 +: 3] = o;
        return r;
    endfunction

    // detector levels need two sync edges and one register edge
    task automatic drive(input logic [22:0] v);
        @(posedge clk_sys_i);
        det_i <= det_t'(v);
        repeat (4) @(posedge clk_sys_i);
        #1;
    endtask

    // let a few edges pass, then look once settled
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    // power-on: 4 cycles low, then room for the two-flop release
    task automatic do_reset();
        rst_n_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
    endtask

    // ==========================================================
    // verdict, reached from the tests or the watchdog
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // watchdog, far beyond the few hundred cycles of the tests
    initial begin
        #100000;
        n_errors++;
        end_of_test();
    end

    // ==========================================================
    // main sequence
    initial begin
        do_reset();
        rd(`FEM_A_PWR_MEM, `FEM_PWR_MEM_RST);
        rd(`FEM_A_PWR_MEM, 8'h00);
        rd(`FEM_A_PWR_STA, 8'h00);
        rd(`FEM_A_CTRL, `FEM_CTRL_RST);
        check("chan", chan_state_o, chv(CH_HIZ, 0, CH_HIZ));
        // unmapped and read-only places refuse writes
        host.write_reg(4'hf, 8'hff);
        host.write_reg(`FEM_A_PWR_STA, 8'hff);
        rd(4'hf, 8'h00);
        rd(`FEM_A_PWR_STA, 8'h00);
        rd(`FEM_A_CTRL, 8'h00);
        // host rewrites its configuration: all channels play
        host.write_reg(`FEM_A_CTRL, 8'hf0);
        step(3);
        check("chan", chan_state_o, chv(CH_PLAY, 0, CH_PLAY));
        // supply faults, one after another
        for (i = 0; i < 5; i++) begin
            ev = 12'h1 << i;
            drive(23'h1 << (22 - i));
            check("chan", chan_state_o, chv(CH_PSD_AR, 0, CH_PSD_AR));
            rd(`FEM_A_PWR_STA, ev[7:0]);
            rd(`FEM_A_PWR_MEM, ev[7:0]);
            drive(23'h0);
            check("chan", chan_state_o, chv(CH_PLAY, 0, CH_PLAY));
            rd(`FEM_A_PWR_STA, 8'h00);
            rd(`FEM_A_PWR_MEM, ev[7:0]);
            rd(`FEM_A_PWR_MEM, 8'h00);
        end
        // channel 2 over-temp latches until cleared
        drive(23'h1 << 13);
        check("chan", chan_state_o, chv(CH_PLAY, 1, CH_PSD));
        rd(`FEM_A_STATE12, 8'h53);
        rd(`FEM_A_STATE34, 8'h33);
        rd(`FEM_A_OT_STA, 8'h02);
        drive(23'h0);
        check("chan", chan_state_o, chv(CH_PLAY, 1, CH_PSD));
        rd(`FEM_A_OT_STA, 8'h00);
        rd(`FEM_A_OT_MEM, 8'h02);
        host.write_reg(`FEM_A_CTRL, 8'h01);
        step(2);
        check("chan", chan_state_o, chv(CH_HIZ, 0, CH_HIZ));
        rd(`FEM_A_CTRL, 8'h00);
        // over-temp with auto recovery selected
        host.write_reg(`FEM_A_CTRL, 8'hf2);
        drive(23'h1 << 16);
        check("chan", chan_state_o, chv(CH_PSD_AR, 0, CH_PSD_AR));
        rd(`FEM_A_OT_STA, 8'h10);
        drive(23'h0);
        check("chan", chan_state_o, chv(CH_PLAY, 0, CH_PLAY));
        rd(`FEM_A_OT_MEM, 8'h10);
        host.write_reg(`FEM_A_CTRL, 8'hf0);
        // transient channel events: over-current, dc, load current
        for (i = 0; i < 3; i++) begin
            drive(i == 0 ? 23'h400 : (i == 1 ? 23'h80 : 23'h1));
            drive(23'h0);
            ev = chv(CH_PLAY, i == 0 ? 2 : (i == 1 ? 3 : 0), CH_PSD);
            check("chan", chan_state_o, ev);
            rd(`FEM_A_OCDC_MEM, i == 0 ? 8'h04 : (i == 1 ? 8'h80 : 8'h01));
            rd(`FEM_A_LOAD_MEM, i == 2 ? 8'h01 : 8'h00);
            rd(`FEM_A_OT_STA, 8'h00);
            rd(`FEM_A_PWR_STA, 8'h00);
            host.write_reg(`FEM_A_CTRL, 8'hf1);
            step(3);
            check("chan", chan_state_o, chv(CH_PLAY, 0, CH_PLAY));
        end
        // sync clock loss counts only as clock follower
        drive(23'h1 << 17);
        check("chan", chan_state_o, chv(CH_PLAY, 0, CH_PLAY));
        host.write_reg(`FEM_A_CTRL, 8'hf4);
        step(3);
        check("chan", chan_state_o, chv(CH_PSD_AR, 0, CH_PSD_AR));
        rd(`FEM_A_OT_STA, 8'h20);
        drive(23'h0);
        check("chan", chan_state_o, chv(CH_PLAY, 0, CH_PLAY));
        rd(`FEM_A_OT_MEM, 8'h20);
        // a low clock enable freezes every flop but the reset release pipe, sync stages too
        @(posedge clk_sys_i);
        ce_i <= 1'b0;
        drive(23'h1 << 22);
        check("frozen", chan_state_o, chv(CH_PLAY, 0, CH_PLAY));
        @(posedge clk_sys_i);
        ce_i <= 1'b1;
        step(3);
        check("chan", chan_state_o, chv(CH_PSD_AR, 0, CH_PSD_AR));
        // core supply drop with a latched fault pending
        drive(23'h400);
        @(posedge clk_sys_i);
        det_i   <= '0;
        rst_n_i <= 1'b0;
        #1;
        check("chan", chan_state_o, chv(CH_HIZ, 0, CH_HIZ));
        do_reset();
        rd(`FEM_A_PWR_MEM, `FEM_PWR_MEM_RST);
        rd(`FEM_A_OCDC_MEM, 8'h00);
        rd(`FEM_A_CTRL, `FEM_CTRL_RST);
        check("chan", chan_state_o, chv(CH_HIZ, 0, CH_HIZ));
        end_of_test();
    end
endmodule
